// File: pnc_coef_bank.sv
// Purpose: Read/write coefficient bank A6h..ADh and the phase correction it steers.
// Assumes: Register port from the serial control interface, same clock domain.
// Notes: Unmapped reads return zero; unmapped writes are dropped.
`timescale 1ns/1ns
module pnc_coef_bank (
    input wire logic i_core_clk, // Core clock, 250 MHz
    input wire logic i_rst, // Synchronous reset, active high
    input wire pnc_pkg::pnc_reg_req_type i_reg, // Register request
    output logic [23:0] o_reg_rdata, // Read data
    output logic o_reg_rvalid, // Read data valid pulse
    input wire pnc_pkg::pnc_phase_type i_sample, // Measured phase sample
    output pnc_pkg::pnc_phase_type o_sample // Corrected phase sample
);

    typedef struct packed {
        logic [pnc_pkg::NUM_REGS-1:0][23:0] bank;
        logic [23:0] rdata;
        logic rvalid;
    } pnc_bank_state_type;

    pnc_bank_state_type state;
    pnc_bank_state_type next_state;
    pnc_pkg::pnc_coef_set_type sel_coef;

    // Map an address to a bank slot; hit is low outside the bank
    function automatic logic [3:0] slot_of(input logic [7:0] addr);
        logic [7:0] rel;
        rel = addr - pnc_pkg::ADDR_CUBIC_HI_CH2L;
        if (addr >= pnc_pkg::ADDR_CUBIC_HI_CH2L && addr <= pnc_pkg::ADDR_QUARTIC_LO_CH1L) begin
            return {1'b1, rel[2:0]};
        end
        return 4'h0;
    endfunction

    // Byte field of a stored register
    function automatic logic [7:0] hi_byte(input logic [23:0] r);
        return r[pnc_pkg::BYTE_FIELD_MSB:pnc_pkg::BYTE_FIELD_LSB];
    endfunction

    // Word field of a stored register
    function automatic logic [15:0] lo_word(input logic [23:0] r);
        return r[pnc_pkg::WORD_FIELD_MSB:pnc_pkg::WORD_FIELD_LSB];
    endfunction

    // Stored register by address
    function automatic logic [23:0] reg_at(
        input logic [pnc_pkg::NUM_REGS-1:0][23:0] bank,
        input logic [7:0] addr
    );
        logic [3:0] s;
        s = slot_of(addr);
        return s[3] ? bank[s[2:0]] : 24'h000000;
    endfunction

    // ------------------------------------------------------------------
    // Register access
    // ------------------------------------------------------------------
    // Reads are registered so the port sees one fixed latency
    always_comb begin
        logic [3:0] wslot;
        wslot = slot_of(i_reg.addr);
        next_state = state;
        next_state.rvalid = i_reg.rd;
        next_state.rdata = i_reg.rd ? reg_at(state.bank, i_reg.addr) : state.rdata; // [R7]
        if (i_reg.wr && wslot[3]) begin
            next_state.bank[wslot[2:0]] = i_reg.wdata; // [R7]
        end
    end

    // State register; every field clears to zero
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            state <= '0; // [R7]
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------
    // Coefficient set selection
    // ------------------------------------------------------------------
    // Terms held outside this bank read as zero here; their owner adds them elsewhere
    always_comb begin
        logic [23:0] r_a6, r_a7, r_a8, r_a9, r_aa, r_ab, r_ac, r_ad;
        r_a6 = reg_at(state.bank, pnc_pkg::ADDR_CUBIC_HI_CH2L);
        r_a7 = reg_at(state.bank, pnc_pkg::ADDR_COEF_C3LO_CH2L_C1_CH0H);
        r_a8 = reg_at(state.bank, pnc_pkg::ADDR_COEF_C3HI_CH2H_C1_CH1L);
        r_a9 = reg_at(state.bank, pnc_pkg::ADDR_COEF_C3LO_CH2H_C1_CH1H);
        r_aa = reg_at(state.bank, pnc_pkg::ADDR_COEF_C4HI_CH0H_C1_CH2L);
        r_ab = reg_at(state.bank, pnc_pkg::ADDR_COEF_C4LO_CH0H_C1_CH2H);
        r_ac = reg_at(state.bank, pnc_pkg::ADDR_COEF_C4HI_CH1L_C2_CH0H);
        r_ad = reg_at(state.bank, pnc_pkg::ADDR_QUARTIC_LO_CH1L);
        sel_coef = '0;
        unique case ({i_sample.channel, i_sample.high_current}) // [R8]
            {pnc_pkg::CH_EMITTER_0, 1'b1}: begin
                sel_coef.linear = lo_word(r_a7); // [R3]
                sel_coef.quadratic = lo_word(r_ac); // [R6]
                sel_coef.quartic = {hi_byte(r_aa), hi_byte(r_ab)}; // [R4]
            end
            {pnc_pkg::CH_EMITTER_1, 1'b0}: begin
                sel_coef.linear = lo_word(r_a8); // [R3]
                sel_coef.quadratic = lo_word(r_ad);
                sel_coef.quartic = {hi_byte(r_ac), hi_byte(r_ad)}; // [R5] [R9]
            end
            {pnc_pkg::CH_EMITTER_1, 1'b1}: begin
                sel_coef.linear = lo_word(r_a9); // [R3]
            end
            {pnc_pkg::CH_EMITTER_2, 1'b0}: begin
                sel_coef.linear = lo_word(r_aa); // [R3]
                sel_coef.cubic = {hi_byte(r_a6), hi_byte(r_a7)}; // [R1] [R10]
            end
            {pnc_pkg::CH_EMITTER_2, 1'b1}: begin
                sel_coef.linear = lo_word(r_ab); // [R3]
                sel_coef.cubic = {hi_byte(r_a8), hi_byte(r_a9)}; // [R2]
            end
            default: begin
                sel_coef = '0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Correction stage
    // ------------------------------------------------------------------
    pnc_poly_correct u_poly (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_sample(i_sample),
        .i_coef(sel_coef),
        .o_sample(o_sample)
    );

    assign o_reg_rdata = state.rdata;
    assign o_reg_rvalid = state.rvalid;

endmodule

// File: pnc_pkg.sv
// Purpose: Shared constants and carrier types for the phase nonlinearity coefficient bank.
// Assumes: A 24-bit register port behind the serial control interface, one clock.
// Notes: Offsets, field positions and reset values are named here once.
// How it works
// [R1] Offset 0xa7 bits 23:16 hold the cubic low byte, channel 2, low current.
// [R2] Channel 2 high-current cubic: high byte 0xa8[23:16], low byte 0xa9[23:16].
// [R3] Linear terms sit in bits 15:0 of offsets 0xa7 through 0xab in fixed order.
// [R4] Channel 0 high-current quartic: high byte 0xaa[23:16], low byte 0xab[23:16].
// [R5] Offset 0xac bits 23:16 hold the quartic high byte, channel 1, low current.
// [R6] Offset 0xac bits 15:0 hold the quadratic term, channel 0, high current.
// [R7] All fields are host readable and writable and reset to zero.
// [R8] One coefficient set per channel and current level, chosen by the active level.
// [R9] Register ADh bits 23:16 hold the quartic low byte, channel 1, low current.
// [R10] Register A6h bits 23:16 hold the cubic high byte, channel 2, low current.
// [R11] Byte pairs join into 16-bit terms applied as a polynomial to the phase.
package pnc_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CUBIC_HI_CH2L = 8'ha6;
    localparam logic [7:0] ADDR_COEF_C3LO_CH2L_C1_CH0H = 8'ha7;
    localparam logic [7:0] ADDR_COEF_C3HI_CH2H_C1_CH1L = 8'ha8;
    localparam logic [7:0] ADDR_COEF_C3LO_CH2H_C1_CH1H = 8'ha9;
    localparam logic [7:0] ADDR_COEF_C4HI_CH0H_C1_CH2L = 8'haa;
    localparam logic [7:0] ADDR_COEF_C4LO_CH0H_C1_CH2H = 8'hab;
    localparam logic [7:0] ADDR_COEF_C4HI_CH1L_C2_CH0H = 8'hac;
    localparam logic [7:0] ADDR_QUARTIC_LO_CH1L = 8'had;
    localparam int NUM_REGS = 8;
    localparam logic [23:0] REG_RESET = 24'h000000;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int BYTE_FIELD_MSB = 23;
    localparam int BYTE_FIELD_LSB = 16;
    localparam int WORD_FIELD_MSB = 15;
    localparam int WORD_FIELD_LSB = 0;
    localparam int FRAC_BITS = 16;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CH_EMITTER_0 = 2'h0,
        CH_EMITTER_1 = 2'h1,
        CH_EMITTER_2 = 2'h2
    } pnc_channel_type;

    typedef struct packed {
        logic signed [15:0] linear;
        logic signed [15:0] quadratic;
        logic signed [15:0] cubic;
        logic signed [15:0] quartic;
    } pnc_coef_set_type;

    typedef struct packed {
        logic valid;
        logic [1:0] channel;
        logic high_current;
        logic [15:0] phase;
    } pnc_phase_type;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [23:0] wdata;
    } pnc_reg_req_type;

endpackage

// File: pnc_poly_correct.sv
// Purpose: Polynomial correction of one phase sample with a selected coefficient set.
// Assumes: Phase is an unsigned fraction of a full cycle; terms are signed Q1.15-like.
// Notes: One registered stage; result wraps modulo a full phase cycle.
`timescale 1ns/1ns
module pnc_poly_correct (
    input wire logic i_core_clk, // Core clock
    input wire logic i_rst, // Synchronous reset, active high
    input wire pnc_pkg::pnc_phase_type i_sample, // Phase sample with its selection
    input wire pnc_pkg::pnc_coef_set_type i_coef, // Coefficient set for that selection
    output pnc_pkg::pnc_phase_type o_sample // Corrected sample, one cycle later
);

    typedef struct packed {
        pnc_pkg::pnc_phase_type out;
    } pnc_poly_state_type;

    pnc_poly_state_type state;
    pnc_poly_state_type next_state;

    // Scale a signed term by the phase fraction, keeping the top bits
    function automatic logic signed [15:0] scale_by_phase(
        input logic signed [15:0] term,
        input logic [15:0] x
    );
        logic signed [32:0] prod;
        prod = term * $signed({1'b0, x});
        return prod[31:16];
    endfunction

    // ------------------------------------------------------------------
    // Horner evaluation
    // ------------------------------------------------------------------
    // Horner form keeps every product 16 by 16 so one cycle suffices at 250 MHz budget
    always_comb begin
        logic signed [15:0] acc;
        acc = 16'sh0000;
        next_state = state;
        acc = i_coef.quartic;
        acc = scale_by_phase(acc, i_sample.phase) + i_coef.cubic;
        acc = scale_by_phase(acc, i_sample.phase) + i_coef.quadratic;
        acc = scale_by_phase(acc, i_sample.phase) + i_coef.linear;
        acc = scale_by_phase(acc, i_sample.phase);
        next_state.out.valid = i_sample.valid;
        next_state.out.channel = i_sample.channel;
        next_state.out.high_current = i_sample.high_current;
        next_state.out.phase = i_sample.phase + acc; // [R11]
    end

    // State register
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign o_sample = state.out;

endmodule

// File: pnc_host.sv
// Purpose: Host model on the coefficient register port
// Assumes: Requests taken at the rising edge, read data one cycle later
// Notes: Idle address and data are inverted so stale values never match
`timescale 1ns/1ns
module pnc_host (
    input wire logic i_core_clk, // Clock
    input wire logic [23:0] i_rdata, // Read data
    input wire logic i_rvalid, // Read valid
    output pnc_pkg::pnc_reg_req_type o_reg // Request
);
    // Quiet port until the first transfer
    initial o_reg = '0;
    // One transfer; read data is taken while the one-cycle valid stands
    task automatic xfer(input logic w, r, input logic [7:0] a, input logic [23:0] d,
        output logic [23:0] q);
        @(posedge i_core_clk) o_reg <= '{a, w, r, d};
        @(posedge i_core_clk) o_reg <= '{~a, 1'b0, 1'b0, ~d};
        @(negedge i_core_clk) q = i_rvalid === 1'b1 ? i_rdata : 24'hxxxxxx;
    endtask
endmodule

// File: pnc_coef_bank_asserts.sv
// Purpose: Port checks for the coefficient bank
// Assumes: One clock, synchronous active-high reset
// Notes: Readback is checked for a read two cycles after a write
`timescale 1ns/1ns
module pnc_coef_bank_asserts (
    input wire logic i_core_clk, // Clock
    input wire logic i_rst, // Reset
    input wire pnc_pkg::pnc_reg_req_type i_reg, // Request
    input wire logic [23:0] o_reg_rdata, // Read data
    input wire logic o_reg_rvalid, // Read valid
    input wire pnc_pkg::pnc_phase_type i_sample, // Sample in
    input wire pnc_pkg::pnc_phase_type o_sample // Sample out
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    // Words outside the bank must read as zero
    wire mapped = i_reg.addr inside {[8'ha6:8'had]};
    sequence wr_s;
        i_reg.wr && !i_reg.rd && mapped;
    endsequence
    // Written word is recovered from history, so no local variables are needed
    property readback_p;
        wr_s ##1 !i_reg.wr ##1 (i_reg.rd && !i_reg.wr && i_reg.addr == $past(i_reg.addr, 2))
            |=> o_reg_rdata == $past(i_reg.wdata, 3);
    endproperty
    write_readback_a: assert property (readback_p)
        else $error("readback differs from written word");
    rd_latency_a: assert property (i_reg.rd |=> o_reg_rvalid)
        else $error("read valid missing");
    rvalid_pulse_a: assert property (!i_reg.rd |=> !o_reg_rvalid)
        else $error("read valid without read");
    unmapped_zero_a: assert property (i_reg.rd && !mapped |=> o_reg_rdata == 24'h000000)
        else $error("unmapped read not zero");
    rdata_hold_a: assert property (!i_reg.rd |=> $stable(o_reg_rdata))
        else $error("read data moved without read");
    // Reset itself must not mask this one
    reset_clear_a: assert property (disable iff (1'b0) i_rst |=>
        o_reg_rdata == 24'h000000 && !o_reg_rvalid && o_sample == '0)
        else $error("outputs not cleared by reset");
    sample_tag_a: assert property (i_sample.valid |=> o_sample.valid &&
        o_sample.channel == $past(i_sample.channel) &&
        o_sample.high_current == $past(i_sample.high_current)) else $error("sample tag lost");
    zero_set_a: assert property (i_sample.valid && (i_sample.channel == 2'h3 ||
        (i_sample.channel == 2'h0 && !i_sample.high_current))
        |=> o_sample.phase == $past(i_sample.phase)) else $error("empty set changed phase");
endmodule
bind pnc_coef_bank pnc_coef_bank_asserts i_pnc_coef_bank_asserts (.i_core_clk, .i_rst,
    .i_reg, .o_reg_rdata, .o_reg_rvalid, .i_sample, .o_sample);

// File: tb_pnc_coef_bank.sv
// Purpose: Self-checking bench for the coefficient bank
// Assumes: 4 ns clock; the host model runs one transfer at a time
// Notes: Expected phases come from a local copy of the correction
`timescale 1ns/1ns
module tb_pnc_coef_bank;
    typedef struct {logic [7:0] a; logic [23:0] d; logic [23:0] e;} pnc_row_type;
    // Word written beside word read back; first and last rows are unmapped
    pnc_row_type rows [10] = '{'{8'ha5, 24'h123456, 24'h0}, '{8'ha6, 24'h051111, 24'h051111},
        '{8'ha7, 24'h220a00, 24'h220a00}, '{8'ha8, 24'hfe0300, 24'hfe0300},
        '{8'ha9, 24'h33f800, 24'h33f800}, '{8'haa, 24'h021000, 24'h021000},
        '{8'hab, 24'h44e000, 24'h44e000}, '{8'hac, 24'hff0700, 24'hff0700},
        '{8'had, 24'h80f900, 24'h80f900}, '{8'hae, 24'h654321, 24'h0}};
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    pnc_pkg::pnc_reg_req_type i_reg;
    logic [23:0] o_reg_rdata, q;
    logic o_reg_rvalid;
    pnc_pkg::pnc_phase_type i_sample = '0;
    pnc_pkg::pnc_phase_type o_sample;
    logic [23:0] m [6:13];
    int n_errors = 0;
    int n_compared = 0;
    int cyc = 0;
    pnc_coef_bank i_pnc_coef_bank (.i_core_clk, .i_rst, .i_reg, .o_reg_rdata, .o_reg_rvalid,
        .i_sample, .o_sample);
    pnc_host i_pnc_host (.i_core_clk, .i_rdata(o_reg_rdata), .i_rvalid(o_reg_rvalid),
        .o_reg(i_reg));
    always #2 i_core_clk = ~i_core_clk;
    // Hang guard; the full run needs under a hundred cycles
    always @(posedge i_core_clk) begin
        cyc++;
        if (cyc == 2000) begin
            n_errors++;
            test_done();
        end
    end
    task automatic chk(input string nm, input logic [23:0] e, s);
        n_compared++;
        if (s !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic test_done();
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    function automatic logic [15:0] fx(logic [15:0] t, x);
        logic signed [31:0] p;
        p = $signed(t) * $signed({1'b0, x});
        return p[31:16];
    endfunction
    // Set s is channel*2+level; small terms keep the accumulator from wrapping
    function automatic logic [15:0] exp_ph(int s, logic [15:0] x);
        logic [15:0] c1, c2, c3, c4;
        {c1, c2, c3, c4} = '0;
        case (s)
            1: {c1, c2, c4} = {m[7][15:0], m[12][15:0], m[10][23:16], m[11][23:16]};
            2: {c1, c2, c4} = {m[8][15:0], m[13][15:0], m[12][23:16], m[13][23:16]};
            3: c1 = m[9][15:0];
            4: {c1, c3} = {m[10][15:0], m[6][23:16], m[7][23:16]};
            5: {c1, c3} = {m[11][15:0], m[8][23:16], m[9][23:16]};
            default: ;
        endcase
        return x + fx(fx(fx(fx(c4, x) + c3, x) + c2, x) + c1, x);
    endfunction
    initial begin
        repeat (2) @(posedge i_core_clk);
        i_rst <= 1'b0;
        // Each word reads zero before its write, then reads back
        foreach (rows[i]) begin
            i_pnc_host.xfer(1'b0, 1'b1, rows[i].a, 24'h0, q);
            chk("reset word", 24'h0, q);
            i_pnc_host.xfer(1'b1, 1'b0, rows[i].a, rows[i].d, q);
            i_pnc_host.xfer(1'b0, 1'b1, rows[i].a, 24'h0, q);
            chk("readback", rows[i].e, q);
            if (rows[i].a inside {[8'ha6:8'had]}) m[rows[i].a - 8'ha0] = rows[i].d;
        end
        $display("test register table done");
        // Back-to-back samples over every set and the unused channel code
        for (int s = 0; s < 9; s++) begin
            @(posedge i_core_clk);
            if (s < 8) begin
                i_sample <= '{1'b1, s[2:1], s[0], 16'(s * 32'h1800 + 32'h2000)};
            end else begin
                i_sample <= '0;
            end
            @(negedge i_core_clk);
            if (s > 0) chk("phase", exp_ph(s - 1, 16'((s - 1) * 32'h1800 + 32'h2000)),
                o_sample.phase);
            if (s > 0) chk("sample tag", 24'({1'b1, 3'(s - 1)}), 24'(o_sample[19:16]));
        end
        $display("test phase sets done");
        // Read and write of one word in one cycle return the old word
        i_pnc_host.xfer(1'b1, 1'b1, 8'hac, 24'h5a5a5a, q);
        chk("read during write", m[12], q);
        i_pnc_host.xfer(1'b0, 1'b1, 8'hac, 24'h0, q);
        chk("after write", 24'h5a5a5a, q);
        $display("test same cycle done");
        // Reset in mid-run clears the bank again
        @(posedge i_core_clk) i_rst <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        i_rst <= 1'b0;
        i_pnc_host.xfer(1'b0, 1'b1, 8'hac, 24'h0, q);
        chk("cleared word", 24'h0, q);
        $display("test second reset done");
        test_done();
    end
endmodule
